// [include/awd_map.vh]
`ifndef AWD_MAP_VH
`define AWD_MAP_VH

// bus geometry
`define AWD_ADDR_W         12
`define AWD_DATA_W         32

// register indices; byte address is four times the index
`define AWD_IDX_ABOVE_LO   8'hc4
`define AWD_IDX_ABOVE_HI   8'hc5
`define AWD_IDX_BELOW_LO   8'hc6
`define AWD_IDX_BELOW_HI   8'hc7
`define AWD_IDX_RESULT_LO  8'hbe
`define AWD_IDX_RESULT_HI  8'hbf
`define AWD_IDX_CONTROL    8'he8
`define AWD_IDX_IRQ_STAT   8'hf0
`define AWD_IDX_IRQ_MASK   8'hf1
`define AWD_ADDR(idx)      ({2'h0, (idx), 2'h0})

// limit byte reset values
`define AWD_RST_ABOVE_LO   8'hff
`define AWD_RST_ABOVE_HI   8'hff
`define AWD_RST_BELOW_LO   8'h00
`define AWD_RST_BELOW_HI   8'h00
`define AWD_RST_BYTE       8'h00
`define AWD_RST_WORD       16'h0000

// control register fields
`define AWD_CTL_LJUST      0
`define AWD_CTL_WHIT       1
`define AWD_CTL_CDONE      5

// interrupt status and mask fields
`define AWD_IRQ_W          2
`define AWD_IRQ_WHIT       0
`define AWD_IRQ_CDONE      1
`define AWD_RST_IRQ        2'h0

// result formatting
`define AWD_RAW_W          12
`define AWD_WORD_W         16
`define AWD_PAD_W          4
`define AWD_SIGN_BIT       11
`define AWD_WORD_MSB       15

`endif

// [core/awd_result_format.v]
`timescale 1ns/10ps
`include "awd_map.vh"

module awd_result_format (
   // raw conversion
   input  wire [`AWD_RAW_W-1:0]  rawData,
   input  wire                   diffMode,
   // format select
   input  wire                   leftJust,
   // formatted word
   output reg  [`AWD_WORD_W-1:0] fmtWord
);

   always @* begin
      if (leftJust) begin
         fmtWord = {rawData, {`AWD_PAD_W{1'b0}}}; // [RQ14]
      end else if (diffMode) begin
         fmtWord = {{`AWD_PAD_W{rawData[`AWD_SIGN_BIT]}}, rawData}; // [RQ13]
      end else begin
         fmtWord = {{`AWD_PAD_W{1'b0}}, rawData}; // [RQ13]
      end
   end

endmodule // awd_result_format

// [core/awd_window_compare.v]
`timescale 1ns/10ps
`include "awd_map.vh"

module awd_window_compare (
   // operands
   input  wire [`AWD_WORD_W-1:0] resultWord,
   input  wire [`AWD_WORD_W-1:0] aboveLimit,
   input  wire [`AWD_WORD_W-1:0] belowLimit,
   input  wire                   signedMode,
   // verdict
   output wire                   inBand
);

   // flipping the msb turns a signed compare into an unsigned one
   wire [`AWD_WORD_W-1:0] flip = {signedMode, {(`AWD_WORD_W-1){1'b0}}};
   wire [`AWD_WORD_W-1:0] res  = resultWord ^ flip; // [RQ8] [RQ10]
   wire [`AWD_WORD_W-1:0] gtL  = aboveLimit ^ flip;
   wire [`AWD_WORD_W-1:0] ltL  = belowLimit ^ flip;

   wire overAbove  = res > gtL; // [RQ16]
   wire underBelow = res < ltL; // [RQ16]
   wire insideMode = ltL > gtL; // [RQ5]

   assign inBand = insideMode ? (overAbove & underBelow)  // [RQ6]
                              : (overAbove | underBelow); // [RQ7]

endmodule // awd_window_compare

// [core/awd_window_detector.v]
// Operation
// [RQ1] every completed conversion is checked against both limit words
// [RQ2] window hit flag is pollable and also drives the interrupt line; irq follows a separate hit status bit instead, masked and cleared on read
// [RQ3] limits load as high and low bytes through separate registers
// [RQ4] limit word is high byte over low byte
// [RQ5] inside or outside band chosen only by ordering of limits
// [RQ6] below limit above the other: flag when strictly between both
// [RQ7] below limit under the other: flag when strictly outside either
// [RQ8] differential results and limits compare as signed 16-bit words
// [RQ9] left-justified results compare as the left-aligned word
// [RQ10] left-justified differential words compare signed too
// [RQ11] a miss leaves the window flag untouched
// [RQ12] window flag holds until software writes it to zero
// [RQ13] right-justified: upper bits sign-extend if differential, else zero
// [RQ14] justify bit: zero right-justified, one left with low nibble zero
// [RQ15] compare uses the stored result word, flag updates that cycle
// [RQ16] a result equal to a limit never satisfies that limit
`timescale 1ns/10ps
`include "awd_map.vh"

module awd_window_detector (
   // clock and reset
   input  wire                   sys_clk,
   input  wire                   rstn,
   // apb slave
   input  wire [`AWD_ADDR_W-1:0] paddr,
   input  wire                   psel,
   input  wire                   penable,
   input  wire                   pwrite,
   input  wire [`AWD_DATA_W-1:0] pwdata,
   output reg  [`AWD_DATA_W-1:0] prdata,
   output wire                   pready,
   output reg                    pslverr,
   // converter core
   input  wire                   convDone,
   input  wire [`AWD_RAW_W-1:0]  convData,
   input  wire                   convDiff,
   // system
   output wire                   irq,
   output wire                   windowHitFlag
);

   // register addresses
   localparam [`AWD_ADDR_W-1:0] ADDR_RES_LO =
      `AWD_ADDR(`AWD_IDX_RESULT_LO);
   localparam [`AWD_ADDR_W-1:0] ADDR_RES_HI =
      `AWD_ADDR(`AWD_IDX_RESULT_HI);
   localparam [`AWD_ADDR_W-1:0] ADDR_CTL =
      `AWD_ADDR(`AWD_IDX_CONTROL);
   localparam [`AWD_ADDR_W-1:0] ADDR_STAT =
      `AWD_ADDR(`AWD_IDX_IRQ_STAT);
   localparam [`AWD_ADDR_W-1:0] ADDR_MASK =
      `AWD_ADDR(`AWD_IDX_IRQ_MASK);

   // limit reset values, highest index first
   localparam [31:0] LIM_RST = {
      `AWD_RST_BELOW_HI,
      `AWD_RST_BELOW_LO,
      `AWD_RST_ABOVE_HI,
      `AWD_RST_ABOVE_LO
   };

   // bus phases
   wire setupPh  = psel & ~penable;
   wire accessPh = psel & penable;
   wire wrEn     = accessPh & pwrite;
   wire rdDone   = accessPh & ~pwrite;

   // zero wait state: read data is captured in the setup cycle
   assign pready = 1'b1;

   // limit byte storage
   reg  [7:0] limByte_r [0:3];
   wire [3:0] limSel;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : gLim
         localparam integer IDXI = `AWD_IDX_ABOVE_LO + g;
         localparam [7:0] IDX = IDXI[7:0];
         localparam [`AWD_ADDR_W-1:0] ADDR = `AWD_ADDR(IDX);

         assign limSel[g] = (paddr == ADDR);

         always @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
               limByte_r[g] <= LIM_RST[g*8 +: 8];
            end else if (wrEn && limSel[g]) begin
               limByte_r[g] <= pwdata[7:0]; // [RQ3]
            end
         end
      end
   endgenerate

   // assembled limit words
   wire [`AWD_WORD_W-1:0] aboveLimit = {limByte_r[1], limByte_r[0]}; // [RQ4]
   wire [`AWD_WORD_W-1:0] belowLimit = {limByte_r[3], limByte_r[2]}; // [RQ4]

   // other decodes
   wire selResLo = (paddr == ADDR_RES_LO);
   wire selResHi = (paddr == ADDR_RES_HI);
   wire selCtl   = (paddr == ADDR_CTL);
   wire selStat  = (paddr == ADDR_STAT);
   wire selMask  = (paddr == ADDR_MASK);
   wire mapped   = (|limSel) | selResLo | selResHi | selCtl |
                   selStat | selMask;

   // control register
   reg  leftJust_r;
   reg  leftJust_nxt;
   reg  winHit_r;
   reg  winHit_nxt;
   reg  convFlag_r;
   reg  convFlag_nxt;

   // result word
   reg  [`AWD_WORD_W-1:0] result_r;
   reg  [`AWD_WORD_W-1:0] result_nxt;

   // interrupt state
   reg  [`AWD_IRQ_W-1:0]  irqStat_r;
   reg  [`AWD_IRQ_W-1:0]  irqStat_nxt;
   reg  [`AWD_IRQ_W-1:0]  irqMask_r;
   reg  [`AWD_IRQ_W-1:0]  irqMask_nxt;
   wire [`AWD_IRQ_W-1:0]  irqEvent;

   // formatting and compare
   wire [`AWD_WORD_W-1:0] fmtWord;
   wire                   inBand;
   wire                   hitEvent;

   awd_result_format uFormat (
      .rawData  (convData),
      .diffMode (convDiff),
      .leftJust (leftJust_r),
      .fmtWord  (fmtWord)
   );

   // the word that lands in the result register is the word compared
   awd_window_compare uCompare (
      .resultWord (fmtWord),    // [RQ15] [RQ9]
      .aboveLimit (aboveLimit),
      .belowLimit (belowLimit),
      .signedMode (convDiff),   // [RQ8] [RQ10]
      .inBand     (inBand)
   );

   assign hitEvent = convDone & inBand; // [RQ1]

   // result register
   always @* begin
      result_nxt = result_r;
      if (convDone) begin
         result_nxt = fmtWord; // [RQ15]
      end
   end

   // control register next state
   always @* begin
      leftJust_nxt = leftJust_r;
      winHit_nxt   = winHit_r;
      convFlag_nxt = convFlag_r;
      if (wrEn && selCtl) begin
         leftJust_nxt = pwdata[`AWD_CTL_LJUST];
         winHit_nxt   = pwdata[`AWD_CTL_WHIT];  // [RQ12]
         convFlag_nxt = pwdata[`AWD_CTL_CDONE];
      end
      // hardware set wins over a software clear in the same cycle
      if (hitEvent) begin
         winHit_nxt = 1'b1; // [RQ6] [RQ7] [RQ15]
      end
      if (convDone) begin
         convFlag_nxt = 1'b1;
      end
      // no path clears the flag on a miss [RQ11]
   end

   // interrupt events
   assign irqEvent[`AWD_IRQ_WHIT]  = hitEvent; // [RQ2]
   assign irqEvent[`AWD_IRQ_CDONE] = convDone;

   // status clears on read, events arriving then still stick
   always @* begin
      irqStat_nxt = irqStat_r;
      if (rdDone && selStat) begin
         irqStat_nxt = `AWD_RST_IRQ;
      end
      irqStat_nxt = irqStat_nxt | irqEvent;
   end

   always @* begin
      irqMask_nxt = irqMask_r;
      if (wrEn && selMask) begin
         irqMask_nxt = pwdata[`AWD_IRQ_W-1:0];
      end
   end

   // state registers
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         leftJust_r <= 1'b0;
         winHit_r   <= 1'b0;
         convFlag_r <= 1'b0;
         result_r   <= `AWD_RST_WORD;
         irqStat_r  <= `AWD_RST_IRQ;
         irqMask_r  <= `AWD_RST_IRQ;
      end else begin
         leftJust_r <= leftJust_nxt;
         winHit_r   <= winHit_nxt;
         convFlag_r <= convFlag_nxt;
         result_r   <= result_nxt;
         irqStat_r  <= irqStat_nxt;
         irqMask_r  <= irqMask_nxt;
      end
   end

   // read data mux
   reg [`AWD_DATA_W-1:0] rdMux;

   always @* begin
      rdMux = {`AWD_DATA_W{1'b0}};
      if (limSel[0]) begin
         rdMux[7:0] = limByte_r[0];
      end
      if (limSel[1]) begin
         rdMux[7:0] = limByte_r[1];
      end
      if (limSel[2]) begin
         rdMux[7:0] = limByte_r[2];
      end
      if (limSel[3]) begin
         rdMux[7:0] = limByte_r[3];
      end
      if (selResLo) begin
         rdMux[7:0] = result_r[7:0];
      end
      if (selResHi) begin
         rdMux[7:0] = result_r[`AWD_WORD_MSB:8];
      end
      if (selCtl) begin
         rdMux[`AWD_CTL_LJUST] = leftJust_r;
         rdMux[`AWD_CTL_WHIT]  = winHit_r; // [RQ2]
         rdMux[`AWD_CTL_CDONE] = convFlag_r;
      end
      if (selStat) begin
         rdMux[`AWD_IRQ_W-1:0] = irqStat_r;
      end
      if (selMask) begin
         rdMux[`AWD_IRQ_W-1:0] = irqMask_r;
      end
   end

   // read data and error are registered in the setup cycle, so they
   // stand steady through the access cycle; unmapped reads give zero
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prdata  <= {`AWD_DATA_W{1'b0}};
         pslverr <= 1'b0;
      end else if (setupPh) begin
         prdata  <= pwrite ? {`AWD_DATA_W{1'b0}} : rdMux;
         pslverr <= ~mapped;
      end else if (!psel) begin
         pslverr <= 1'b0;
      end
   end

   // outputs
   assign windowHitFlag = winHit_r; // [RQ2]
   assign irq = |(irqStat_r & irqMask_r); // [RQ2]

endmodule // awd_window_detector

// [verif/awd_conv_model.sv]
`timescale 1ns/10ps

module awd_conv_model (
   // clock
   input  wire        sys_clk,
   // conversion result
   output reg         convDone,
   output reg  [11:0] convData,
   output reg         convDiff
);
   initial begin
      convDone = 1'b0;
      convData = 12'h000;
      convDiff = 1'b0;
   end

   // gap makes slow cores; stale data scrambled, never held
   task convert(input logic [11:0] d, input logic df, input int gap);
      repeat (gap) @(posedge sys_clk);
      convDone <= 1'b1;
      convData <= d;
      convDiff <= df;
      @(posedge sys_clk);
      convDone <= 1'b0;
      convData <= ~d;
      convDiff <= ~df;
   endtask
endmodule // awd_conv_model

// [verif/awd_checker.sv]
`timescale 1ns/10ps

module awd_checker (
   // clock and reset
   input wire        sys_clk,
   input wire        rstn,
   // apb
   input wire [11:0] paddr,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // converter and system
   input wire        convDone,
   input wire [11:0] convData,
   input wire        convDiff,
   input wire        irq,
   input wire        windowHitFlag
);
   logic [7:0] limit_r [4];
   logic       just_r;
   logic       mask_r;
   wire        wr = psel && penable && pwrite;
   wire        ctlWr = wr && paddr == 12'h3a0;
   wire        cause = convDone || wr;
   // limit bytes mirrored from writes, index in paddr[3:2]
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         limit_r <= '{8'hff, 8'hff, 8'h00, 8'h00};
         just_r <= 1'b0;
         mask_r <= 1'b0;
      end else if (wr) begin
         if (paddr[11:4] == 8'h31) limit_r[paddr[3:2]] <= pwdata[7:0];
         if (ctlWr) just_r <= pwdata[0];
         if (paddr == 12'h3c4) mask_r <= pwdata[0];
      end
   end
   wire [15:0] sgn = {convDiff, 15'h0};
   wire [15:0] res = just_r ? {convData, 4'h0} :
                     {{4{convDiff & convData[11]}}, convData};
   // flipping the sign bit lets one unsigned compare serve both
   wire [15:0] r = res ^ sgn;
   wire [15:0] a = {limit_r[1], limit_r[0]} ^ sgn;
   wire [15:0] b = {limit_r[3], limit_r[2]} ^ sgn;
   wire        hit = (b > a) ? (r > a && r < b) : (r < b || r > a);

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   hit_sets_a:
      assert property (convDone && hit && !wr |=> windowHitFlag)
      else $error("hit not flagged");
   miss_keeps_a:
      assert property (convDone && !hit && !wr |=> $stable(windowHitFlag))
      else $error("miss changed flag");
   flag_fall_a:
      assert property ($fell(windowHitFlag) |-> $past(ctlWr))
      else $error("flag cleared by itself");
   flag_rise_a:
      assert property ($rose(windowHitFlag) |-> $past(cause))
      else $error("flag set without cause");
   irq_hit_a:
      assert property (convDone && hit && !wr && mask_r |=> irq)
      else $error("no interrupt on hit");
   irq_rise_a:
      assert property ($rose(irq) |-> $past(cause))
      else $error("interrupt without event");
   rdy_const_a: assert property (pready) else $error("pready low");
   err_unmap_a:
      assert property (psel && penable && paddr == 12'h000 |-> pslverr)
      else $error("unmapped not refused");
   err_idle_a: assert property (!psel && !$past(psel) |-> !pslverr)
      else $error("pslverr when idle");
   inside_c: cover property (convDone && hit && b > a);
   outside_c: cover property (convDone && hit && b <= a);
   irq_c: cover property ($rose(irq));
endmodule // awd_checker

bind awd_window_detector awd_checker chk (.sys_clk(sys_clk), .rstn(rstn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .convDone(convDone), .convData(convData), .convDiff(convDiff),
   .irq(irq), .windowHitFlag(windowHitFlag));

// [verif/testbench.sv]
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("[ERR] %0t %h %h", $time, (a), (e)); end end

module testbench;
   localparam logic [11:0] CTL = 12'h3a0, IST = 12'h3c0, IMK = 12'h3c4;
   localparam logic [11:0] RLO = 12'h2f8, RHI = 12'h2fc;
   logic        sys_clk, rstn, psel, penable, pwrite, lj, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, rdat;
   wire  [31:0] prdata;
   wire  [11:0] convData;
   wire         pready, pslverr, irq, windowHitFlag, convDone, convDiff;
   int          n_errors = 0;
   int          n_checks = 0;

   awd_window_detector dut (.sys_clk(sys_clk), .rstn(rstn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .convDone(convDone), .convData(convData), .convDiff(convDiff),
      .irq(irq), .windowHitFlag(windowHitFlag));
   awd_conv_model cm (.sys_clk(sys_clk), .convDone(convDone),
      .convData(convData), .convDiff(convDiff));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // entered just after an edge; one idle cycle after each transfer
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge sys_clk) penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task rd(input logic [11:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h0);
      `CHK(rdat, e)
   endtask
   task lim(input logic [15:0] b, input logic [15:0] a);
      apb(1'b1, 12'h310, {24'h0, a[7:0]});
      apb(1'b1, 12'h314, {24'h0, a[15:8]});
      apb(1'b1, 12'h318, {24'h0, b[7:0]});
      apb(1'b1, 12'h31c, {24'h0, b[15:8]});
   endtask
   // clears the flag first, so each hit is seen on its own
   task cv(input logic [11:0] d, input logic df, input logic e);
      apb(1'b1, CTL, {31'h0, lj});
      cm.convert(d, df, int'(d[1:0]));
      #1 `CHK(windowHitFlag, e)
      @(posedge sys_clk);
   endtask

   task t_regs;
      rd(12'h314, 32'hff);
      rd(12'h318, 32'h00);
      apb(1'b0, 12'h000, 32'h0);
      `CHK({err, rdat}, 33'h100000000)
      lim(16'h1234, 16'h5678);
      rd(12'h31c, 32'h12);
      rd(12'h310, 32'h78);
   endtask
   task t_inside;
      lj = 1'b0;
      lim(16'h0200, 16'h0100);
      cv(12'h180, 1'b0, 1'b1);
      cv(12'h101, 1'b0, 1'b1);
      cv(12'h200, 1'b0, 1'b0);
      cv(12'h100, 1'b0, 1'b0);
      cv(12'h201, 1'b0, 1'b0);
   endtask
   task t_outside;
      lim(16'h0100, 16'h0200);
      cv(12'h0ff, 1'b0, 1'b1);
      cv(12'h100, 1'b0, 1'b0);
      cv(12'h180, 1'b0, 1'b0);
      cv(12'h201, 1'b0, 1'b1);
   endtask
   task t_diff;
      lim(16'h0100, 16'hffff);
      cv(12'h000, 1'b1, 1'b1);
      cv(12'hfff, 1'b1, 1'b0);
      lim(16'h0100, 16'hf000);
      cv(12'hfff, 1'b1, 1'b1);
      rd(RHI, 32'hff);
      cv(12'hfff, 1'b0, 1'b0);
      rd(RHI, 32'h0f);
   endtask
   task t_left;
      lj = 1'b1;
      lim(16'h2000, 16'h1000);
      cv(12'h1ff, 1'b0, 1'b1);
      cv(12'h200, 1'b0, 1'b0);
      cv(12'h101, 1'b0, 1'b1);
      rd(RLO, 32'h10);
      lim(16'h1000, 16'hfff0);
      cv(12'h000, 1'b1, 1'b1);
      cv(12'hffe, 1'b1, 1'b0);
      lim(16'hfff0, 16'h1000);
      cv(12'hffe, 1'b1, 1'b1);
      cv(12'hfff, 1'b1, 1'b0);
   endtask
   task t_sticky;
      lj = 1'b0;
      lim(16'h0200, 16'h0100);
      // drain events left by earlier scenarios so the irq rise is real
      rd(IST, 32'h3);
      apb(1'b1, IMK, 32'h1);
      `CHK(irq, 1'b0)
      cv(12'h180, 1'b0, 1'b1);
      `CHK(irq, 1'b1)
      cm.convert(12'h300, 1'b0, 0);
      @(posedge sys_clk);
      `CHK(windowHitFlag, 1'b1)
      rd(CTL, 32'h22);
      rd(IST, 32'h3);
      `CHK({irq, windowHitFlag}, 2'b01)
      apb(1'b1, CTL, 32'h0);
      `CHK(windowHitFlag, 1'b0)
      apb(1'b1, IMK, 32'h0);
      cv(12'h180, 1'b0, 1'b1);
      `CHK(irq, 1'b0)
   endtask

   task final_report;
      if (n_errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      {rstn, psel, penable, pwrite, lj} = 5'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      t_regs;
      t_inside;
      t_outside;
      t_diff;
      t_left;
      t_sticky;
      final_report;
   end
   // run needs about 1.2 us
   initial begin
      #40000;
      n_errors++;
      final_report;
   end
endmodule // testbench
